// [core/dsi_pkg.sv]
// constants, fault classes and lamp modes for the drive status and i/o block
// assumes one 125 mhz system clock shared by every user of this package
package dsi_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam longint CLK_PERIOD_NS = 8;
	localparam longint BRAKE_DELAY_NS = 333_333_333; // one third of a second
	// least time, so round up to whole cycles
	localparam int BRAKE_DELAY_CYC = int'((BRAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam longint BLINK_PERIOD_NS = 500_000_000;
	localparam longint BLINK_ON_NS = 250_000_000;
	localparam int BLINK_PERIOD_CYC = int'(BLINK_PERIOD_NS / CLK_PERIOD_NS);
	localparam int BLINK_ON_CYC = int'(BLINK_ON_NS / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// sizes and field positions
	// ----------------------------------------------------------------
	localparam int NUM_GPI = 6;
	localparam int NUM_GPO = 2;
	localparam int NUM_FLT = 8;
	localparam int SRC_W = 16;
	localparam int SEL_W = 4;
	localparam int FOLLOW_SHIFT = 3; // warning at one eighth of the limit

	// fault class bit positions; lower index wins a tie
	localparam int FLT_MOTION = 0;
	localparam int FLT_OVERV = 1;
	localparam int FLT_UNDERV = 2;
	localparam int FLT_OVERCUR = 3;
	localparam int FLT_COMM = 4;
	localparam int FLT_INTERNAL = 5;
	localparam int FLT_FOLLOW = 6;
	localparam int FLT_OTHER = 7;

	// status source bit positions for the outputs
	localparam int SRC_FAULT_STOP = 0;
	localparam int SRC_FOLLOW_WARN = 1;
	localparam int SRC_TARGET = 2;
	localparam int SRC_READY = 3;
	localparam int SRC_HOMING = 4;
	localparam int SRC_HOME_SW = 5;
	localparam int SRC_FLT_BASE = 6;
	localparam int SRC_DISABLED = 14;

	// ----------------------------------------------------------------
	// lamp modes and per-lamp patterns
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		LM_UNCFG = 6'h01,
		LM_INIT = 6'h02,
		LM_RUN = 6'h04,
		LM_RECOV = 6'h08,
		LM_DISABLED = 6'h10,
		LM_FAULT = 6'h20
	} dsi_lamp_mode_t;

	typedef enum logic [1:0] {
		LP_OFF = 2'h0,
		LP_ON = 2'h1,
		LP_BLINK = 2'h2
	} dsi_lamp_pat_t;

	// values after reset
	localparam logic [5:0] GPI_RST = 6'h00;
	localparam logic [2:0] FLT_IDX_RST = 3'h0;

endpackage

// [core/dsi_top.sv]
// status outputs, user input decoding, status lamps and brake timing
// assumes fault and state flags come from logic on i_sys_clk, while the
// general-purpose input pins and the home switch arrive asynchronously
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - each of two outputs shows one configured status or fault bit
// R2 - fault-stop source is high while the drive is stopped by any fault
// R3 - tracking warning when following error exceeds one eighth of fault limit
// R4 - target-reached source is high once the motion command completes
// R5 - servo-ready source is high while user motion commands are accepted
// R6 - homing-active source follows homing; home-switch source mirrors the switch
// R7 - each of six inputs can drive one or more internal functions
// R8 - disable input level stops motor control and lets the motor free-wheel
// R9 - rising edge on clear-fault input clears all active faults
// R10 - rising edge on homing-start input begins homing
// R11 - rising edge on sequence input starts the sequence linked to it
// R12 - several functions may share one input pin
// R13 - lamps show only the first latched fault, later ones ignored
// R14 - unconfigured: green blinks, outputs off, brake engaged until power cycle
// R15 - initialisation: green and blue blink, motor driven, brake released
// R16 - recovering: green blinks, blue steady, motor driven, brake released
// R17 - motion fault: green and red blink, electric braking, brake engaged
// R18 - bus voltage fault: blue and red blink; brake under, float over
// R19 - overcurrent: green and red blink, blue on, outputs float, brake
// R20 - communication fault: all lamps blink, electric braking, brake engaged
// R21 - internal fault: green blinks, blue and red on, outputs float
// R22 - mechanical brake engages one third second after error or disable
// R23 - inputs are synchronised and rising edges become single-cycle pulses
// R24 - blinking comes from one shared divider with parameter period and duty
module dsi_top
	import dsi_pkg::*;
#(
	parameter int BRAKE_DLY = BRAKE_DELAY_CYC,
	parameter int BLINK_PER = BLINK_PERIOD_CYC,
	parameter int BLINK_ON = BLINK_ON_CYC
)
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// pins from the machine controller
	input wire logic [NUM_GPI-1:0] i_gpi,
	input wire logic i_home_sw,
	// configuration
	input wire logic [SEL_W-1:0] i_gpo0_sel,
	input wire logic [SEL_W-1:0] i_gpo1_sel,
	input wire logic [NUM_GPI-1:0] i_map_disable,
	input wire logic [NUM_GPI-1:0] i_map_clear,
	input wire logic [NUM_GPI-1:0] i_map_home,
	input wire logic [NUM_GPI-1:0] i_map_seq,
	// drive state
	input wire logic i_unconfigured,
	input wire logic i_init_active,
	input wire logic i_recovering,
	input wire logic i_servo_ready,
	input wire logic i_motion_done,
	input wire logic i_homing_active,
	input wire logic [15:0] i_follow_err,
	input wire logic [13:0] i_follow_limit,
	input wire logic [NUM_FLT-1:0] i_fault,
	// user outputs and actions
	output logic [NUM_GPO-1:0] o_gpo,
	output logic o_disable,
	output logic o_clear_faults,
	output logic o_home_start,
	output logic [NUM_GPI-1:0] o_seq_start,
	// lamps
	output logic o_green_indicator,
	output logic o_blue_indicator,
	output logic o_red_indicator,
	// motor stage, brake and fault latch
	output logic o_motor_hiz,
	output logic o_motor_brake,
	output logic o_mech_brake,
	output logic o_fault_stop,
	output logic [2:0] o_first_fault
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_GPI-1:0] gpi_s1;
		logic [NUM_GPI-1:0] gpi_s2;
		logic [NUM_GPI-1:0] gpi_s3;
		logic [NUM_GPI-1:0] gpi_lvl;
		logic hsw_s1;
		logic hsw_s2;
		logic hsw_s3;
		logic hsw_lvl;
		logic uncfg;
		logic flt_valid;
		logic [2:0] flt_idx;
		dsi_lamp_mode_t mode;
		logic [31:0] brk_cnt;
		logic [31:0] blk_cnt;
		logic blink;
		logic [NUM_GPO-1:0] gpo;
		logic dis;
		logic clr;
		logic home;
		logic [NUM_GPI-1:0] seq;
		logic green;
		logic blue;
		logic red;
		logic hiz;
		logic ebrk;
		logic mbrk;
	} dsi_state_t;

	dsi_state_t st_r;
	dsi_state_t st_nxt;

	// ----------------------------------------------------------------
	// lamp pattern to level
	// ----------------------------------------------------------------
	function automatic logic lamp(input dsi_lamp_pat_t p, input logic b);
		lamp = (p == LP_ON) | ((p == LP_BLINK) & b);
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic [NUM_GPI-1:0] rise;
	logic [SRC_W-1:0] src;
	logic clr_now;
	logic stopped;
	dsi_lamp_pat_t pg;
	dsi_lamp_pat_t pb;
	dsi_lamp_pat_t pr;

	always_comb
	begin
		st_nxt = st_r;
		pg = LP_OFF;
		pb = LP_OFF;
		pr = LP_OFF;

		// three-stage synchronisers, level taken when stages two and three agree
		st_nxt.gpi_s1 = i_gpi; // [R23]
		st_nxt.gpi_s2 = st_r.gpi_s1;
		st_nxt.gpi_s3 = st_r.gpi_s2;
		// per bit: agreeing stages set the level, disagreeing stages keep the old one
		st_nxt.gpi_lvl = (st_r.gpi_s2 & st_r.gpi_s3) |
			(st_r.gpi_lvl & (st_r.gpi_s2 ^ st_r.gpi_s3)); // [R23]
		st_nxt.hsw_s1 = i_home_sw;
		st_nxt.hsw_s2 = st_r.hsw_s1;
		st_nxt.hsw_s3 = st_r.hsw_s2;
		if (st_r.hsw_s2 == st_r.hsw_s3)
		begin
			st_nxt.hsw_lvl = st_r.hsw_s2; // [R6]
		end
		rise = st_nxt.gpi_lvl & ~st_r.gpi_lvl; // [R23]

		// input functions, any mix may share a pin
		st_nxt.dis = |(st_r.gpi_lvl & i_map_disable); // [R7] [R8] [R12]
		st_nxt.clr = |(rise & i_map_clear); // [R9] [R12]
		st_nxt.home = |(rise & i_map_home); // [R10]
		st_nxt.seq = rise & i_map_seq; // [R11]
		clr_now = st_r.clr;

		// unconfigured latches until reset, i.e. logic power cycle
		if (i_unconfigured)
		begin
			st_nxt.uncfg = 1'b1; // [R14]
		end

		// first fault latch: clear drops it, a fault in the same cycle wins
		if (clr_now)
		begin
			st_nxt.flt_valid = 1'b0; // [R9]
		end
		if (!st_nxt.flt_valid && (|i_fault))
		begin
			st_nxt.flt_valid = 1'b1; // [R13]
			for (int k = NUM_FLT - 1; k >= 0; k--)
			begin
				if (i_fault[k])
				begin
					st_nxt.flt_idx = 3'(k);
				end
			end
		end

		// status sources
		src = '0;
		src[SRC_FAULT_STOP] = st_r.flt_valid; // [R2]
		src[SRC_FOLLOW_WARN] = i_follow_err >
			{5'h00, i_follow_limit[13:FOLLOW_SHIFT]}; // [R3]
		src[SRC_TARGET] = i_motion_done; // [R4]
		src[SRC_READY] = i_servo_ready; // [R5]
		src[SRC_HOMING] = i_homing_active; // [R6]
		src[SRC_HOME_SW] = st_r.hsw_lvl; // [R6]
		src[SRC_FLT_BASE +: NUM_FLT] = i_fault;
		src[SRC_DISABLED] = st_r.dis;
		st_nxt.gpo[0] = src[i_gpo0_sel]; // [R1]
		st_nxt.gpo[1] = src[i_gpo1_sel]; // [R1]

		// operating mode for lamps and motor stage
		if (st_r.uncfg)
		begin
			st_nxt.mode = LM_UNCFG;
		end
		else if (st_r.flt_valid)
		begin
			st_nxt.mode = LM_FAULT;
		end
		else if (st_r.dis)
		begin
			st_nxt.mode = LM_DISABLED;
		end
		else if (i_recovering)
		begin
			st_nxt.mode = LM_RECOV;
		end
		else if (i_init_active)
		begin
			st_nxt.mode = LM_INIT;
		end
		else
		begin
			st_nxt.mode = LM_RUN;
		end

		// shared blink divider
		if (st_r.blk_cnt >= 32'(BLINK_PER - 1))
		begin
			st_nxt.blk_cnt = '0;
		end
		else
		begin
			st_nxt.blk_cnt = st_r.blk_cnt + 32'h1;
		end
		st_nxt.blink = st_r.blk_cnt < 32'(BLINK_ON); // [R24]

		// lamp patterns and motor stage per mode
		st_nxt.hiz = 1'b0;
		st_nxt.ebrk = 1'b0;
		stopped = 1'b0;
		case (st_r.mode)
			LM_UNCFG:
			begin
				pg = LP_BLINK; // [R14]
				st_nxt.hiz = 1'b1;
			end
			LM_INIT:
			begin
				pg = LP_BLINK; // [R15]
				pb = LP_BLINK;
			end
			LM_RUN:
			begin
				pb = LP_ON;
			end
			LM_RECOV:
			begin
				pg = LP_BLINK; // [R16]
				pb = LP_ON;
			end
			LM_DISABLED:
			begin
				pb = LP_BLINK;
				st_nxt.hiz = 1'b1; // [R8]
				stopped = 1'b1;
			end
			LM_FAULT:
			begin
				stopped = 1'b1;
				st_nxt.ebrk = 1'b1;
				case (st_r.flt_idx)
					3'(FLT_MOTION):
					begin
						pg = LP_BLINK; // [R17]
						pr = LP_BLINK;
					end
					3'(FLT_OVERV):
					begin
						pb = LP_BLINK; // [R18]
						pr = LP_BLINK;
						st_nxt.ebrk = 1'b0;
						st_nxt.hiz = 1'b1;
					end
					3'(FLT_UNDERV):
					begin
						pb = LP_BLINK; // [R18]
						pr = LP_BLINK;
					end
					3'(FLT_OVERCUR):
					begin
						pg = LP_BLINK; // [R19]
						pb = LP_ON;
						pr = LP_BLINK;
						st_nxt.ebrk = 1'b0;
						st_nxt.hiz = 1'b1;
					end
					3'(FLT_COMM):
					begin
						pg = LP_BLINK; // [R20]
						pb = LP_BLINK;
						pr = LP_BLINK;
					end
					3'(FLT_INTERNAL):
					begin
						pg = LP_BLINK; // [R21]
						pb = LP_ON;
						pr = LP_ON;
						st_nxt.ebrk = 1'b0;
						st_nxt.hiz = 1'b1;
					end
					3'(FLT_FOLLOW):
					begin
						pr = LP_BLINK;
					end
					default:
					begin
						pr = LP_ON;
					end
				endcase
			end
			default:
			begin
				st_nxt.hiz = 1'b1;
			end
		endcase
		st_nxt.green = lamp(pg, st_r.blink);
		st_nxt.blue = lamp(pb, st_r.blink);
		st_nxt.red = lamp(pr, st_r.blink);

		// mechanical brake: immediate when unconfigured, delayed when stopped
		if (!stopped)
		begin
			st_nxt.brk_cnt = '0;
		end
		else if (st_r.brk_cnt < 32'(BRAKE_DLY))
		begin
			st_nxt.brk_cnt = st_r.brk_cnt + 32'h1; // [R22]
		end
		st_nxt.mbrk = (st_r.mode == LM_UNCFG) |
			(stopped & (st_r.brk_cnt >= 32'(BRAKE_DLY))); // [R14] [R22]
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			st_r <= '0;
			st_r.mode <= LM_RUN;
			st_r.gpi_lvl <= GPI_RST;
			st_r.flt_idx <= FLT_IDX_RST;
			st_r.hiz <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign o_gpo = st_r.gpo;
	assign o_disable = st_r.dis;
	assign o_clear_faults = st_r.clr;
	assign o_home_start = st_r.home;
	assign o_seq_start = st_r.seq;
	assign o_green_indicator = st_r.green;
	assign o_blue_indicator = st_r.blue;
	assign o_red_indicator = st_r.red;
	assign o_motor_hiz = st_r.hiz;
	assign o_motor_brake = st_r.ebrk;
	assign o_mech_brake = st_r.mbrk;
	assign o_fault_stop = st_r.flt_valid;
	assign o_first_fault = st_r.flt_idx;

endmodule

`default_nettype wire

// [sim/dsi_top_assertions.sv]
// port assertions for the status, input and lamp block
// bound into every dsi_top instance at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module dsi_top_chk
	import dsi_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// watched inputs
	input wire logic [SEL_W-1:0] i_gpo0_sel,
	input wire logic i_unconfigured,
	input wire logic i_servo_ready,
	input wire logic [15:0] i_follow_err,
	input wire logic [13:0] i_follow_limit,
	input wire logic [NUM_FLT-1:0] i_fault,
	// watched outputs
	input wire logic [NUM_GPO-1:0] o_gpo,
	input wire logic o_disable,
	input wire logic o_clear_faults,
	input wire logic o_home_start,
	input wire logic o_blue_indicator,
	input wire logic o_red_indicator,
	input wire logic o_motor_hiz,
	input wire logic o_motor_brake,
	input wire logic o_mech_brake,
	input wire logic o_fault_stop,
	input wire logic [2:0] o_first_fault
);
	// helper terms for the source relations
	logic any_flt;
	logic warn_now;
	assign any_flt = |i_fault;
	assign warn_now = i_follow_err > {5'h00, i_follow_limit[13:3]};

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_sys_rst);

	// overcurrent latch, then floating stage with steady blue lamp
	sequence s_oc_latch;
		$rose(o_fault_stop) && o_first_fault == 3'h3;
	endsequence
	sequence s_float_stop;
		o_motor_hiz && !o_motor_brake && o_blue_indicator;
	endsequence

	AST_FLT_SET: assert property (!o_fault_stop |=> o_fault_stop == $past(any_flt))
		else $error("fault stop does not follow faults");
	AST_FLT_HOLD: assert property (o_fault_stop && !o_clear_faults |=>
		o_fault_stop && $stable(o_first_fault)) else $error("latched fault changed");
	AST_OC_STOP: assert property (s_oc_latch |-> ##2 s_float_stop)
		else $error("overcurrent stop wrong");
	AST_BRAKE_WAIT: assert property ($rose(o_fault_stop) && !o_mech_brake &&
		!i_unconfigured |=> !o_mech_brake [*8]) else $error("brake engaged early");
	AST_UNCFG: assert property (i_unconfigured |-> ##4 o_motor_hiz && o_mech_brake
		&& !o_red_indicator && !o_blue_indicator) else $error("unconfigured stop wrong");
	AST_CLR_PULSE: assert property (o_clear_faults |=> !o_clear_faults)
		else $error("clear pulse too long");
	AST_HOME_PULSE: assert property (o_home_start |=> !o_home_start)
		else $error("homing pulse too long");
	AST_READY: assert property (i_gpo0_sel == 4'h3 |=> o_gpo[0] == $past(i_servo_ready))
		else $error("ready source wrong");
	AST_WARN: assert property (i_gpo0_sel == 4'h1 |=> o_gpo[0] == $past(warn_now))
		else $error("warning source wrong");
	AST_DIS_FREE: assert property ((o_disable && !o_fault_stop) [*3] |->
		o_motor_hiz && !o_motor_brake) else $error("disabled motor not free-wheeling");
endmodule
bind dsi_top dsi_top_chk dsi_top_chk_inst (.i_sys_clk, .i_sys_rst, .i_gpo0_sel,
	.i_unconfigured, .i_servo_ready, .i_follow_err, .i_follow_limit, .i_fault, .o_gpo, .o_disable,
	.o_clear_faults, .o_home_start, .o_blue_indicator, .o_red_indicator, .o_motor_hiz,
	.o_motor_brake, .o_mech_brake, .o_fault_stop, .o_first_fault);
`default_nettype wire

// [sim/dsi_ctrl_model.sv]
// machine controller model: drives the input pins and the home switch
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module dsi_ctrl_model
	import dsi_pkg::*;
(
	// clock
	input wire logic i_sys_clk,
	// pins toward the drive
	output logic [NUM_GPI-1:0] o_gpi,
	output logic o_home_sw
);
	// pins idle low from time zero
	initial
	begin
		o_gpi = '0;
		o_home_sw = 1'b0;
	end

	// hold one pin high for a number of cycles; one cycle is a glitch
	task automatic pulse(input int pin, input int cyc);
	begin
		o_gpi[pin] = 1'b1;
		repeat (cyc) @(posedge i_sys_clk);
		#1 o_gpi[pin] = 1'b0;
	end
	endtask

	// set the home switch level, the model stays the only writer of the pin
	task automatic set_home(input logic lvl);
	begin
		o_home_sw = lvl;
	end
	endtask
endmodule
`default_nettype wire

// [sim/drive_status_io_and_indicators_tb_top.sv]
// self-checking bench for the status, input and lamp block
// assumes the package, the controller model and the checker compile first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %0t mismatch", $time); end end
module drive_status_io_and_indicators_tb_top;
	import dsi_pkg::*;
	localparam int BDLY = 20;
	logic i_sys_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [5:0] i_gpi;
	logic i_home_sw;
	logic [3:0] i_gpo0_sel = '0, i_gpo1_sel = '0;
	logic [5:0] i_map_disable = '0, i_map_clear = '0, i_map_home = '0, i_map_seq = '0;
	logic i_unconfigured = 0, i_init_active = 0, i_recovering = 0, i_servo_ready = 0;
	logic i_motion_done = 0, i_homing_active = 0;
	logic [15:0] i_follow_err = '0;
	logic [13:0] i_follow_limit = '0;
	logic [7:0] i_fault = '0;
	logic [1:0] o_gpo;
	logic o_disable, o_clear_faults, o_home_start, o_motor_hiz, o_motor_brake, o_mech_brake;
	logic o_green_indicator, o_blue_indicator, o_red_indicator, o_fault_stop;
	logic [5:0] o_seq_start;
	logic [2:0] o_first_fault, hi, lo;
	logic [3:0] nc, nh, ns, nd, ex;
	int error_cnt = 0, n_compared = 0, p, q, len;

	// clock, design and controller
	always #4 i_sys_clk = ~i_sys_clk;
	dsi_top #(.BRAKE_DLY(BDLY), .BLINK_PER(8), .BLINK_ON(4)) dsi_top_inst (.*);
	dsi_ctrl_model dsi_ctrl_model_inst (.i_sys_clk, .o_gpi(i_gpi), .o_home_sw(i_home_sw));

	task automatic tick();
	begin
		@(posedge i_sys_clk);
		#1;
	end
	endtask

	// expected level of one output source
	function automatic logic src_bit(input logic [3:0] s);
		logic [15:0] v;
		v = {2'h0, i_fault, i_home_sw, i_homing_active, i_servo_ready, i_motion_done,
			i_follow_err > (i_follow_limit >> 3), 1'b0};
		return v[s];
	endfunction

	// lamps seen high then seen low, each as green, blue, red
	function automatic logic [5:0] lamp_exp(input int k);
		case (k)
			0: return 6'h2f;
			1, 2: return 6'h1f;
			3: return 6'h3d;
			4: return 6'h3f;
			5: return 6'h3c;
			6: return 6'h0f;
			7: return 6'h0e;
			8: return 6'h37;
			9: return 6'h35;
			default: return 6'h15;
		endcase
	endfunction

	// drop faults and pulse a clear-only pin
	task automatic clear_all();
	begin
		i_fault = 8'h00;
		{i_map_disable, i_map_clear, i_map_home, i_map_seq} = {6'h00, 6'h01, 12'h000};
		dsi_ctrl_model_inst.pulse(0, 5);
		repeat (6) tick();
		`CHK(o_fault_stop, 1'b0)
	end
	endtask

	task automatic report_and_stop();
	begin
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask

	// watchdog well beyond the expected run
	initial
	begin
		repeat (8000) @(posedge i_sys_clk);
		error_cnt++;
		report_and_stop();
	end

	// main sequence
	initial
	begin
		void'($urandom(83));
		repeat (8) tick();
		`CHK({o_motor_hiz, o_fault_stop}, 2'b10)
		i_sys_rst = 1'b0;
		for (int t = 0; t < 40; t++)
		begin
			i_gpo0_sel = 4'($urandom_range(14, 1));
			i_gpo1_sel = (t % 5 == 0) ? 4'hf : 4'($urandom_range(13, 1));
			{i_servo_ready, i_motion_done, i_homing_active} = 3'($urandom);
			i_follow_limit = 14'($urandom);
			i_follow_err = 16'(i_follow_limit >> 3) + 16'(t % 2);
			if (t > 3)
				i_follow_err = 16'($urandom);
			i_fault = (t % 4 == 0) ? 8'($urandom) : 8'h00;
			tick();
			`CHK(o_gpo, {src_bit(i_gpo1_sel), src_bit(i_gpo0_sel)})
		end
		clear_all();
		$display("output source test done");
		i_gpo0_sel = 4'h5;
		for (int v = 1; v >= 0; v--)
		begin
			dsi_ctrl_model_inst.set_home(1'(v));
			repeat (5) tick();
			`CHK(o_gpo[0], 1'(v))
		end
		for (int t = 0; t < 12; t++)
		begin
			p = $urandom_range(5);
			q = (t % 3 == 0) ? p : $urandom_range(5);
			len = (t % 4 == 1) ? 1 : 3 + $urandom_range(4);
			{i_map_disable, i_map_clear, i_map_home, i_map_seq} = {4{6'(1 << p)}};
			{nc, nh, ns, nd} = '0;
			fork
				dsi_ctrl_model_inst.pulse(q, len);
				repeat (14)
				begin
					tick();
					{nc, nh, ns, nd} = {nc + o_clear_faults, nh + o_home_start,
						ns + o_seq_start[p], nd + o_disable};
				end
			join
			ex = 4'(p == q && len > 1);
			`CHK({nc, nh, ns}, {3{ex}})
			`CHK(nd != 4'h0, ex != 4'h0)
		end
		$display("input function test done");
		for (int k = 0; k < 11; k++)
		begin
			i_fault = (k < 8) ? 8'(1 << k) | 8'h80 : 8'h00;
			{i_init_active, i_recovering} = {k == 8, k == 9};
			tick();
			if (k < 8)
			begin
				`CHK({o_fault_stop, o_first_fault}, {1'b1, 3'(k)})
				i_fault = i_fault | 8'h01;
			end
			repeat (2) tick();
			{hi, lo} = '0;
			repeat (8)
			begin
				tick();
				hi = hi | {o_green_indicator, o_blue_indicator, o_red_indicator};
				lo = lo | ~{o_green_indicator, o_blue_indicator, o_red_indicator};
			end
			`CHK({hi, lo}, lamp_exp(k))
			`CHK(o_motor_hiz, 1'(k == 1 || k == 3 || k == 5))
			`CHK(o_motor_brake, 1'(k < 8 && k != 1 && k != 3 && k != 5))
			`CHK(o_mech_brake, 1'b0)
			if (k < 8)
			begin
				repeat (BDLY) tick();
				`CHK(o_mech_brake, 1'b1)
				clear_all();
			end
		end
		$display("lamp and brake test done");
		i_unconfigured = 1'b1;
		tick();
		i_unconfigured = 1'b0;
		repeat (8) tick();
		`CHK({o_motor_hiz, o_mech_brake, o_blue_indicator, o_red_indicator}, 4'hc)
		$display("unconfigured test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
